// *** design/perf_sel_pkg.sv ***
/*
  Shared constants, field layouts and carrier types for the performance
  event qualification block. Assumes a 32-bit AXI4-Lite register bus and
  per-clock micro-op counts from the pipeline, all on one clock.
*/
package perf_sel_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_EVSL = 8'h00;
  localparam logic [7:0] ADDR_CCFG = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  // Field positions
  localparam int SEL_LSB = 25;
  localparam int SEL_W = 7;
  localparam int MASK_LSB = 9;
  localparam int MASK_W = 16;
  localparam int CSEL_LSB = 13;
  localparam int CSEL_W = 3;
  localparam int EN_BIT = 12;
  // Writable bits; the rest read as zero
  localparam logic [31:0] EVSL_WMASK = 32'hfffffe00;
  localparam logic [31:0] CCFG_WMASK = 32'h0000f000;
  // Values after reset
  localparam logic [31:0] EVSL_RST = 32'h00000000;
  localparam logic [31:0] CCFG_RST = 32'h00000000;
  localparam logic [31:0] COUNT_RST = 32'h00000000;
  // Event select codes
  localparam logic [6:0] EV_PI128 = 7'h1a;
  localparam logic [6:0] EV_LEGACY_FP = 7'h04;
  localparam logic [6:0] EV_FV_MOVE = 7'h2e;
  localparam logic [6:0] EV_POWER = 7'h13;
  localparam logic [6:0] EV_SWITCH = 7'h05;
  localparam logic [6:0] EV_QWRITE = 7'h09;
  // Counter configuration select codes
  localparam logic [2:0] CS_FIRM = 3'h1;
  localparam logic [2:0] CS_FSB = 3'h6;
  localparam logic [2:0] CS_UC = 3'h0;
  // Mask bit positions
  localparam int MB_ALL = 15;
  localparam int MB_PORT0 = 3;
  localparam int MB_PORT2 = 4;
  localparam int MB_RUNNING = 0;
  localparam int MB_ROM_XFER = 0;
  localparam int MB_BUILD = 0;
  localparam int MB_DELIVER = 1;
  localparam int MB_ROM_WR = 2;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int INCR_W = 5;

  typedef struct packed {
    logic [6:0] sel;
    logic [15:0] mask;
    logic [2:0] csel;
    logic en;
  } cfg_t;

  typedef struct packed {
    logic [2:0] pi128;
    logic [2:0] fp_stack;
    logic [2:0] fp_stack_lsm;
    logic [2:0] lsm_p0;
    logic [2:0] lsm_p0_int;
    logic [2:0] lsm_p2;
    logic [2:0] lsm_p2_int;
    logic [2:0] qw_build;
    logic [2:0] qw_deliver;
    logic [2:0] qw_rom;
    logic active;
    logic switch_pulse;
  } ev_src_t;

  // Byte-lane merge of a bus write
  function automatic logic [31:0] apply_strb(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[8*i +: 8] = data[8*i +: 8];
    end
    return r;
  endfunction

  // Count passed only when its mask bit is set
  function automatic logic [INCR_W-1:0] gate(input logic en,
    input logic [2:0] n);
    return en ? {2'h0, n} : 5'h00;
  endfunction

  // Qualifying part of a total; never wraps below zero
  function automatic logic [2:0] sat_sub(input logic [2:0] a,
    input logic [2:0] b);
    return (a > b) ? 3'(a - b) : 3'h0;
  endfunction
endpackage

// *** design/event_qualifier.sv ***
/*
  Combinational event decode: turns the configuration fields and the
  per-clock pipeline counts into the amount the counter advances.
  Assumes the caller registers the result where needed.
*/
module event_qualifier (
  input perf_sel_pkg::cfg_t cfg,
  input perf_sel_pkg::ev_src_t ev,
  output logic [perf_sel_pkg::INCR_W-1:0] incr
);
  // Select one event; unlisted codes or a wrong select count nothing
  always_comb
  begin
    incr = 5'h00;
    if (cfg.en)
    begin
      case (cfg.sel)
        perf_sel_pkg::EV_PI128:
          if (cfg.csel == perf_sel_pkg::CS_FIRM)
            incr = perf_sel_pkg::gate(cfg.mask[perf_sel_pkg::MB_ALL],
              ev.pi128);
        perf_sel_pkg::EV_LEGACY_FP:
          if (cfg.csel == perf_sel_pkg::CS_FIRM)
            incr = perf_sel_pkg::gate(cfg.mask[perf_sel_pkg::MB_ALL],
              perf_sel_pkg::sat_sub(ev.fp_stack, ev.fp_stack_lsm));
        perf_sel_pkg::EV_FV_MOVE:
          if (cfg.csel == perf_sel_pkg::CS_FIRM)
            incr = 5'(perf_sel_pkg::gate(cfg.mask[perf_sel_pkg::MB_PORT0],
              perf_sel_pkg::sat_sub(ev.lsm_p0, ev.lsm_p0_int))
              + perf_sel_pkg::gate(cfg.mask[perf_sel_pkg::MB_PORT2],
              perf_sel_pkg::sat_sub(ev.lsm_p2, ev.lsm_p2_int)));
        perf_sel_pkg::EV_POWER:
          if (cfg.csel == perf_sel_pkg::CS_FSB)
            incr = perf_sel_pkg::gate(cfg.mask[perf_sel_pkg::MB_RUNNING],
              {2'h0, ev.active});
        perf_sel_pkg::EV_SWITCH:
          if (cfg.csel == perf_sel_pkg::CS_UC)
            incr = perf_sel_pkg::gate(cfg.mask[perf_sel_pkg::MB_ROM_XFER],
              {2'h0, ev.switch_pulse});
        perf_sel_pkg::EV_QWRITE:
          if (cfg.csel == perf_sel_pkg::CS_UC)
            incr = 5'(perf_sel_pkg::gate(cfg.mask[perf_sel_pkg::MB_BUILD],
              ev.qw_build)
              + perf_sel_pkg::gate(cfg.mask[perf_sel_pkg::MB_DELIVER],
              ev.qw_deliver)
              + perf_sel_pkg::gate(cfg.mask[perf_sel_pkg::MB_ROM_WR],
              ev.qw_rom));
        default:
          incr = 5'h00;
      endcase
    end
  end
endmodule

// *** design/event_counter.sv ***
/*
  The 32-bit event counter. Software may load it; a load in the same
  clock as qualifying events keeps those events. Assumes one clock.
*/
module event_counter (
  input wire logic clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [31:0] load_val,
  input wire logic [perf_sel_pkg::INCR_W-1:0] incr,
  output logic [31:0] count_q
);
  // Whole clock's total is added at once, so no event is dropped
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      count_q <= perf_sel_pkg::COUNT_RST;
    else if (load)
      count_q <= load_val + {27'h0, incr};
    else
      count_q <= count_q + {27'h0, incr};
  end
endmodule

// *** design/perf_event_select_decoder.sv ***
/*
  Performance event qualification block with its AXI4-Lite register
  file: event selection control, counter configuration, counter and
  status. Assumes pipeline counts and levels synchronous to CLK.
*/
// Added by the designer: the register offsets and register access over AXI4-Lite.
// Notes on behaviour
// - Select 1AH with mask bit 15 counts every 128-bit packed integer uop.
// - Each qualifying 128-bit uop counts, not each instruction.
// - Select 04H with config select 01H counts legacy float uops.
// - Mask bit 15 counts all legacy float uops, each one separately.
// - Legacy float event never counts load, store or move uops.
// - Select 2EH counts float/vector load, store and move uops.
// - Those uops are attributed to a mask bit by dispatch port 0 or 2.
// - Mask bit 3 picks stores and moves, mask bit 4 picks loads.
// - Integer moves never count; assist-flow uops still count.
// - Select 013H with config select 06H counts non-stopped cycles.
// - Mask bit 0 counts active time, including halt, clock-stop, throttling.
// - Select 05H counts each switch of delivery from trace cache to ROM.
// - Mask bit 0 qualifies each such delivery transfer.
// - Valid queue writes count; mask bits choose the write sources.
// - Queue mask bit 0 build, bit 1 deliver, bit 2 ROM writes.
module perf_event_select_decoder (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  input wire logic [2:0] PI128_UOPS,
  input wire logic [2:0] FP_STACK_UOPS,
  input wire logic [2:0] FP_STACK_LSM_UOPS,
  input wire logic [2:0] LSM_P0_UOPS,
  input wire logic [2:0] LSM_P0_INT_UOPS,
  input wire logic [2:0] LSM_P2_UOPS,
  input wire logic [2:0] LSM_P2_INT_UOPS,
  input wire logic [2:0] QW_BUILD_UOPS,
  input wire logic [2:0] QW_DELIVER_UOPS,
  input wire logic [2:0] QW_ROM_UOPS,
  input wire logic CPU_RUNNING,
  input wire logic HALT_HANDLING,
  input wire logic CLKSTOP_HANDLING,
  input wire logic THROTTLING,
  input wire logic DELIVERY_FROM_ROM,
  output logic [31:0] COUNT_VALUE,
  output logic EVENT_HIT
);
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] evsl_q;
  logic [31:0] ccfg_q;
  logic rom_prev_q;
  logic [perf_sel_pkg::INCR_W-1:0] incr_q;
  logic event_hit_q;
  logic do_write;
  logic wr_count;
  logic [7:0] wsel;
  logic wr_mapped;
  logic [31:0] count_load;
  logic [perf_sel_pkg::INCR_W-1:0] incr;
  perf_sel_pkg::cfg_t cfg;
  perf_sel_pkg::ev_src_t ev;

  // Low address bits are ignored so every access hits one word
  assign wsel = waddr_q & 8'hfc;
  assign do_write = aw_got_q && w_got_q && !bvalid_q;
  assign wr_mapped = (wsel == perf_sel_pkg::ADDR_EVSL)
    || (wsel == perf_sel_pkg::ADDR_CCFG)
    || (wsel == perf_sel_pkg::ADDR_COUNT)
    || (wsel == perf_sel_pkg::ADDR_STATUS);
  assign wr_count = do_write && (wsel == perf_sel_pkg::ADDR_COUNT);
  assign count_load = perf_sel_pkg::apply_strb(COUNT_VALUE, wdata_q,
    wstrb_q);

  // Configuration fields seen by the decoder
  assign cfg.sel = evsl_q[perf_sel_pkg::SEL_LSB +: perf_sel_pkg::SEL_W];
  assign cfg.mask = evsl_q[perf_sel_pkg::MASK_LSB +: perf_sel_pkg::MASK_W];
  assign cfg.csel = ccfg_q[perf_sel_pkg::CSEL_LSB +: perf_sel_pkg::CSEL_W];
  assign cfg.en = ccfg_q[perf_sel_pkg::EN_BIT];

  // Pipeline sources; assist flows are not filtered out here
  assign ev.pi128 = PI128_UOPS;
  assign ev.fp_stack = FP_STACK_UOPS;
  assign ev.fp_stack_lsm = FP_STACK_LSM_UOPS;
  assign ev.lsm_p0 = LSM_P0_UOPS;
  assign ev.lsm_p0_int = LSM_P0_INT_UOPS;
  assign ev.lsm_p2 = LSM_P2_UOPS;
  assign ev.lsm_p2_int = LSM_P2_INT_UOPS;
  assign ev.qw_build = QW_BUILD_UOPS;
  assign ev.qw_deliver = QW_DELIVER_UOPS;
  assign ev.qw_rom = QW_ROM_UOPS;
  // Halt, clock-stop and throttling handling all count as active
  assign ev.active = CPU_RUNNING || HALT_HANDLING || CLKSTOP_HANDLING
    || THROTTLING;
  // A rise of the ROM-delivery level is one switch away from the cache
  assign ev.switch_pulse = DELIVERY_FROM_ROM && !rom_prev_q;

  event_qualifier u_qual (
    .cfg(cfg),
    .ev(ev),
    .incr(incr)
  );

  event_counter u_count (
    .clk(CLK),
    .rstn(RSTN),
    .load(wr_count),
    .load_val(count_load),
    .incr(incr),
    .count_q(COUNT_VALUE)
  );

  // Write address channel: one address held until the response is taken
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      awready_q <= 1'b1;
      aw_got_q <= 1'b0;
      waddr_q <= 8'h00;
    end
    else if (AWVALID && awready_q)
    begin
      awready_q <= 1'b0;
      aw_got_q <= 1'b1;
      waddr_q <= AWADDR;
    end
    else if (do_write)
      aw_got_q <= 1'b0;
    else if (bvalid_q && BREADY)
      awready_q <= 1'b1;
  end

  // Write data channel, accepted independently of the address
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      wready_q <= 1'b1;
      w_got_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else if (WVALID && wready_q)
    begin
      wready_q <= 1'b0;
      w_got_q <= 1'b1;
      wdata_q <= WDATA;
      wstrb_q <= WSTRB;
    end
    else if (do_write)
      w_got_q <= 1'b0;
    else if (bvalid_q && BREADY)
      wready_q <= 1'b1;
  end

  // Write response; the read-only status word answers with an error too
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= perf_sel_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_mapped && wsel != perf_sel_pkg::ADDR_STATUS)
        ? perf_sel_pkg::RESP_OKAY : perf_sel_pkg::RESP_SLVERR;
    end
    else if (bvalid_q && BREADY)
      bvalid_q <= 1'b0;
  end

  // Configuration registers; reserved bits are never stored
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      evsl_q <= perf_sel_pkg::EVSL_RST;
      ccfg_q <= perf_sel_pkg::CCFG_RST;
    end
    else if (do_write && wsel == perf_sel_pkg::ADDR_EVSL)
      evsl_q <= perf_sel_pkg::apply_strb(evsl_q, wdata_q, wstrb_q)
        & perf_sel_pkg::EVSL_WMASK;
    else if (do_write && wsel == perf_sel_pkg::ADDR_CCFG)
      ccfg_q <= perf_sel_pkg::apply_strb(ccfg_q, wdata_q, wstrb_q)
        & perf_sel_pkg::CCFG_WMASK;
  end

  // Read channel; the word is captured at the address handshake
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= perf_sel_pkg::RESP_OKAY;
    end
    else if (ARVALID && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= perf_sel_pkg::RESP_OKAY;
      unique case (ARADDR & 8'hfc)
        perf_sel_pkg::ADDR_EVSL: rdata_q <= evsl_q;
        perf_sel_pkg::ADDR_CCFG: rdata_q <= ccfg_q;
        perf_sel_pkg::ADDR_COUNT: rdata_q <= COUNT_VALUE;
        perf_sel_pkg::ADDR_STATUS:
          rdata_q <= {22'h000000, ev.active, rom_prev_q, 3'h0, incr_q};
        default:
        begin
          rdata_q <= 32'h00000000;
          rresp_q <= perf_sel_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && RREADY)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Event history for edge detection and status
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rom_prev_q <= 1'b0;
      incr_q <= 5'h00;
      event_hit_q <= 1'b0;
    end
    else
    begin
      rom_prev_q <= DELIVERY_FROM_ROM;
      incr_q <= incr;
      event_hit_q <= (incr != 5'h00);
    end
  end

  assign AWREADY = awready_q;
  assign WREADY = wready_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;
  assign EVENT_HIT = event_hit_q;

  // Checks on the counting behaviour and the write response; loads are excluded as they set the count to the written value plus that clock's events
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  logic firm;
  logic no_load;
  assign firm = cfg.en && cfg.csel == perf_sel_pkg::CS_FIRM;
  assign no_load = !wr_count;

  property p_pi128_all;
    firm && no_load && cfg.sel == perf_sel_pkg::EV_PI128
      && cfg.mask[perf_sel_pkg::MB_ALL]
    |=> COUNT_VALUE == $past(COUNT_VALUE) + 32'($past(PI128_UOPS));
  endproperty
  a_pi128_all: assert property (p_pi128_all)
    else $error("packed integer uops not counted");

  property p_pi128_each;
    firm && no_load && cfg.sel == perf_sel_pkg::EV_PI128
      && cfg.mask[perf_sel_pkg::MB_ALL] && PI128_UOPS == 3'h3
    |=> COUNT_VALUE - $past(COUNT_VALUE) == 32'h3 && EVENT_HIT;
  endproperty
  a_pi128_each: assert property (p_pi128_each)
    else $error("several packed uops did not each count");

  property p_fp_wrong_csel;
    cfg.en && no_load && cfg.sel == perf_sel_pkg::EV_LEGACY_FP
      && cfg.csel != perf_sel_pkg::CS_FIRM
    |=> $stable(COUNT_VALUE);
  endproperty
  a_fp_wrong_csel: assert property (p_fp_wrong_csel)
    else $error("legacy float counted with wrong config select");

  property p_fp_count;
    firm && no_load && cfg.sel == perf_sel_pkg::EV_LEGACY_FP
      && cfg.mask[perf_sel_pkg::MB_ALL]
      && FP_STACK_UOPS >= FP_STACK_LSM_UOPS
    |=> COUNT_VALUE == $past(COUNT_VALUE)
      + 32'($past(FP_STACK_UOPS) - $past(FP_STACK_LSM_UOPS));
  endproperty
  a_fp_count: assert property (p_fp_count)
    else $error("legacy float uop total wrong");

  property p_fp_no_moves;
    firm && no_load && cfg.sel == perf_sel_pkg::EV_LEGACY_FP
      && FP_STACK_UOPS == FP_STACK_LSM_UOPS
    |=> $stable(COUNT_VALUE);
  endproperty
  a_fp_no_moves: assert property (p_fp_no_moves)
    else $error("legacy float event counted a load, store or move");

  property p_move_ports;
    firm && no_load && cfg.sel == perf_sel_pkg::EV_FV_MOVE
      && cfg.mask[perf_sel_pkg::MB_PORT0]
      && !cfg.mask[perf_sel_pkg::MB_PORT2]
      && LSM_P0_UOPS >= LSM_P0_INT_UOPS
    |=> COUNT_VALUE == $past(COUNT_VALUE)
      + 32'($past(LSM_P0_UOPS) - $past(LSM_P0_INT_UOPS));
  endproperty
  a_move_ports: assert property (p_move_ports)
    else $error("store and move uops misattributed by port");

  property p_move_no_int;
    firm && no_load && cfg.sel == perf_sel_pkg::EV_FV_MOVE
      && LSM_P0_UOPS == LSM_P0_INT_UOPS
      && LSM_P2_UOPS == LSM_P2_INT_UOPS
    |=> $stable(COUNT_VALUE);
  endproperty
  a_move_no_int: assert property (p_move_no_int)
    else $error("integer move uops were counted");

  property p_power_active;
    cfg.en && no_load && cfg.sel == perf_sel_pkg::EV_POWER
      && cfg.csel == perf_sel_pkg::CS_FSB
      && cfg.mask[perf_sel_pkg::MB_RUNNING]
    |=> COUNT_VALUE == $past(COUNT_VALUE) + 32'($past(ev.active));
  endproperty
  a_power_active: assert property (p_power_active)
    else $error("non-stopped time not accumulated");

  property p_switch_once;
    cfg.en && no_load && cfg.sel == perf_sel_pkg::EV_SWITCH
      && cfg.csel == perf_sel_pkg::CS_UC
      && cfg.mask[perf_sel_pkg::MB_ROM_XFER]
    |=> COUNT_VALUE - $past(COUNT_VALUE)
      == 32'($past(DELIVERY_FROM_ROM) && !$past(DELIVERY_FROM_ROM, 2));
  endproperty
  a_switch_once: assert property (p_switch_once)
    else $error("delivery switch miscounted");

  property p_qwrite_sources;
    cfg.en && no_load && cfg.sel == perf_sel_pkg::EV_QWRITE
      && cfg.csel == perf_sel_pkg::CS_UC
      && cfg.mask[2:0] == 3'h2
    |=> COUNT_VALUE == $past(COUNT_VALUE) + 32'($past(QW_DELIVER_UOPS));
  endproperty
  a_qwrite_sources: assert property (p_qwrite_sources)
    else $error("queue write source selection wrong");

  property p_qwrite_total;
    cfg.en && no_load && cfg.sel == perf_sel_pkg::EV_QWRITE
      && cfg.csel == perf_sel_pkg::CS_UC && cfg.mask[2:0] == 3'h7
    |=> COUNT_VALUE == $past(COUNT_VALUE) + 32'($past(QW_BUILD_UOPS))
      + 32'($past(QW_DELIVER_UOPS)) + 32'($past(QW_ROM_UOPS));
  endproperty
  a_qwrite_total: assert property (p_qwrite_total)
    else $error("same-clock events not summed");

  property p_bresp_two;
    AWVALID && AWREADY && WVALID && WREADY |=> ##1 BVALID;
  endproperty
  a_bresp_two: assert property (p_bresp_two)
    else $error("write response late");

  c_pi128: cover property (firm && cfg.sel == perf_sel_pkg::EV_PI128
    && PI128_UOPS > 3'h1);
  c_switch: cover property (ev.switch_pulse && cfg.sel ==
    perf_sel_pkg::EV_SWITCH);
  c_qwrite: cover property (cfg.sel == perf_sel_pkg::EV_QWRITE
    && incr > 5'h8);
  c_load_hit: cover property (wr_count && incr != 5'h00);
endmodule

// *** verif/pipe_event_model.sv ***
/*
  Model of the pipeline event sources: per-clock micro-op counts,
  activity levels and the delivery source level.
  Assumes one clock; all outputs idle while go is low.
*/
module pipe_event_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic go,
  output perf_sel_pkg::ev_src_t ev,
  output logic [3:0] lv,
  output logic rom
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] a, b, c;

  // Fresh traffic each clock; integer parts never exceed their totals
  always @(posedge clk or negedge rstn)
  begin
    a = 3'($urandom);
    b = 3'($urandom);
    c = 3'($urandom);
    if (!rstn || !go)
    begin
      ev <= '0;
      lv <= 4'h0;
      rom <= 1'b0;
    end
    else
    begin
      ev.pi128 <= 3'($urandom);
      ev.fp_stack <= a;
      ev.fp_stack_lsm <= 3'($urandom_range(a));
      ev.lsm_p0 <= b;
      ev.lsm_p0_int <= 3'($urandom_range(b));
      ev.lsm_p2 <= c;
      ev.lsm_p2_int <= 3'($urandom_range(c));
      ev.qw_build <= 3'($urandom);
      ev.qw_deliver <= 3'($urandom);
      ev.qw_rom <= 3'($urandom);
      ev.active <= 1'b0;
      ev.switch_pulse <= 1'b0;
      // At least half the clocks have no activity level at all
      lv <= 4'($urandom) & {4{1'($urandom)}};
      rom <= 1'($urandom);
    end
  end
endmodule

// *** verif/perf_event_select_decoder_tb.sv ***
/*
  Self-checking bench: AXI4-Lite master tasks, the event source model
  and a per-clock counter model checked on every falling edge outside register set-up.
  Assumes the design answers well inside the watchdog limit.
*/
module perf_event_select_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RSTN, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY, EVENT_HIT, rom, go, hit_e, p;
  logic chk_on;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, COUNT_VALUE, exp_cnt, v;
  logic [3:0] WSTRB, lv, cc_m;
  logic [1:0] BRESP, RRESP, rs;
  logic [6:0] sel_m;
  logic [15:0] msk_m;
  perf_sel_pkg::ev_src_t ev;
  int n_mismatch, num_checks, cyc;
  // Event set-ups: select, mask, {config select, enable}
  logic [6:0] sl [16] = '{7'h1a, 7'h1a, 7'h1a, 7'h04, 7'h04, 7'h2e,
    7'h2e, 7'h2e, 7'h13, 7'h13, 7'h05, 7'h09, 7'h09, 7'h09, 7'h09, 7'h7f};
  logic [15:0] mk [16] = '{16'h8000, 16'h0000, 16'h8000, 16'h8000,
    16'h8000, 16'h0008, 16'h0010, 16'h0018, 16'h0001, 16'h0001, 16'h0001,
    16'h0001, 16'h0002, 16'h0004, 16'h0007, 16'hffff};
  logic [3:0] cc [16] = '{4'h3, 4'h3, 4'h2, 4'h3, 4'h1, 4'h3, 4'h3, 4'h3,
    4'hd, 4'h3, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h3};

  perf_event_select_decoder dut (
    .CLK, .RSTN, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA,
    .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR,
    .RVALID, .RREADY, .RDATA, .RRESP, .PI128_UOPS(ev.pi128),
    .FP_STACK_UOPS(ev.fp_stack), .FP_STACK_LSM_UOPS(ev.fp_stack_lsm),
    .LSM_P0_UOPS(ev.lsm_p0), .LSM_P0_INT_UOPS(ev.lsm_p0_int),
    .LSM_P2_UOPS(ev.lsm_p2), .LSM_P2_INT_UOPS(ev.lsm_p2_int),
    .QW_BUILD_UOPS(ev.qw_build), .QW_DELIVER_UOPS(ev.qw_deliver),
    .QW_ROM_UOPS(ev.qw_rom), .CPU_RUNNING(lv[0]), .HALT_HANDLING(lv[1]),
    .CLKSTOP_HANDLING(lv[2]), .THROTTLING(lv[3]),
    .DELIVERY_FROM_ROM(rom), .COUNT_VALUE, .EVENT_HIT);

  pipe_event_model src (.clk(CLK), .rstn(RSTN), .go, .ev, .lv, .rom);

  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Write: address and data offered together, held until each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [1:0] r);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do
    begin
      @(posedge CLK);
      if (AWREADY)
        AWVALID <= 1'b0;
      if (WREADY)
        WVALID <= 1'b0;
    end
    while (!BVALID);
    r = BRESP;
    BREADY <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do
    begin
      @(posedge CLK);
      if (ARREADY)
        ARVALID <= 1'b0;
    end
    while (!RVALID);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask

  function automatic logic [4:0] sb(input logic [2:0] a, b);
    return (a > b) ? 5'(a - b) : 5'h0;
  endfunction

  // Expected increment of one clock for the current set-up
  function automatic logic [4:0] f(input perf_sel_pkg::ev_src_t e,
    input logic [3:0] l, input logic r, input logic q);
    logic [4:0] n;
    logic [2:0] cs;
    n = 5'h0;
    cs = cc_m[3:1];
    if (cc_m[0])
      case (sel_m)
        7'h1a: if (cs == 3'h1 && msk_m[15]) n = 5'(e.pi128);
        7'h04: if (cs == 3'h1 && msk_m[15])
          n = sb(e.fp_stack, e.fp_stack_lsm);
        7'h2e: if (cs == 3'h1)
          n = (msk_m[3] ? sb(e.lsm_p0, e.lsm_p0_int) : 5'h0) +
            (msk_m[4] ? sb(e.lsm_p2, e.lsm_p2_int) : 5'h0);
        7'h13: if (cs == 3'h6 && msk_m[0]) n = 5'(|l);
        7'h05: if (cs == 3'h0 && msk_m[0]) n = 5'(r && !q);
        7'h09: if (cs == 3'h0)
          n = (msk_m[0] ? 5'(e.qw_build) : 5'h0) +
            (msk_m[1] ? 5'(e.qw_deliver) : 5'h0) +
            (msk_m[2] ? 5'(e.qw_rom) : 5'h0);
        default: n = 5'h0;
      endcase
    return n;
  endfunction

  // Counter model; the previous delivery level marks a switch
  always @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      p <= 1'b0;
      hit_e <= 1'b0;
    end
    else
    begin
      exp_cnt <= exp_cnt + 32'(f(ev, lv, rom, p));
      hit_e <= f(ev, lv, rom, p) != 5'h0;
      p <= rom;
    end

  // Checked mid-cycle, once the edge's updates have settled
  always @(negedge CLK)
    if (chk_on)
    begin
      chk(COUNT_VALUE, exp_cnt);
      chk({31'h0, EVENT_HIT}, {31'h0, hit_e});
    end

  // Hang guard, far above the thousand or so cycles the run needs
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial
  begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, go, chk_on} = '0;
    {AWADDR, ARADDR, WDATA, WSTRB} = '0;
    {sel_m, msk_m, cc_m, exp_cnt} = '0;
    RSTN = 1'b0;
    v = $urandom(38982);
    repeat (10) @(posedge CLK);
    RSTN <= 1'b1;
    // Reset values, refused accesses, reserved bits, byte lanes
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(4 * i), v, rs);
      chk(v, 32'h0);
    end
    rd(8'h10, v, rs);
    chk({v[31:2], rs}, 32'h2);
    wr(8'h0c, 32'h0, 4'hf, rs);
    chk({30'h0, rs}, 32'h2);
    wr(8'h00, '1, 4'hf, rs);
    rd(8'h00, v, rs);
    chk(v, 32'hfffffe00);
    wr(8'h04, '1, 4'hf, rs);
    rd(8'h04, v, rs);
    chk(v, 32'h0000f000);
    wr(8'h08, 32'h12345678, 4'hf, rs);
    wr(8'h08, '1, 4'h2, rs);
    rd(8'h08, v, rs);
    chk(v, 32'h1234ff78);
    // Every event set-up, with random traffic and a random start count
    foreach (sl[i])
    begin
      chk_on = 1'b0;
      wr(8'h00, {sl[i], mk[i], 9'h0}, 4'hf, rs);
      wr(8'h04, {16'h0, cc[i], 12'h0}, 4'hf, rs);
      v = $urandom;
      wr(8'h08, v, 4'hf, rs);
      #1;
      {sel_m, msk_m, cc_m} = {sl[i], mk[i], cc[i]};
      exp_cnt = v;
      chk_on = 1'b1;
      @(posedge CLK);
      go <= 1'b1;
      repeat (40) @(posedge CLK);
      go <= 1'b0;
      repeat (3) @(posedge CLK);
      rd(8'h08, v, rs);
      chk(v, exp_cnt);
    end
    end_of_test();
  end
endmodule
